/* File: hw/timer_pkg.sv */
// Constants for the prescaled sixteen-bit timer block
package timer_pkg;
  // -----------------------------------------------------------
  // Register indices and byte addresses
  // -----------------------------------------------------------
  localparam logic [7:0] CTRL_IDX  = 8'h05;
  localparam logic [7:0] CPU_IDX   = 8'h06;
  localparam logic [7:0] INT_IDX   = 8'h07;
  localparam logic [7:0] LO_IDX    = 8'h0B;
  localparam logic [7:0] HI_IDX    = 8'h0C;
  localparam logic [7:0] CTRL_ADDR = 8'(CTRL_IDX * 4);
  localparam logic [7:0] CPU_ADDR  = 8'(CPU_IDX * 4);
  localparam logic [7:0] INT_ADDR  = 8'(INT_IDX * 4);
  localparam logic [7:0] LO_ADDR   = 8'(LO_IDX * 4);
  localparam logic [7:0] HI_ADDR   = 8'(HI_IDX * 4);
  // -----------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------
  localparam int EDGE_BIT  = 6;
  localparam int SRC_BIT   = 5;
  localparam int PS_MSB    = 4;
  localparam int PS_LSB    = 1;
  localparam int GID_BIT   = 4;
  localparam int PINF_BIT  = 6;
  localparam int OVFF_BIT  = 5;
  localparam int PINE_BIT  = 2;
  localparam int OVFE_BIT  = 1;
  // Writable bits of the control and cpu status words
  localparam logic [7:0] CTRL_WMASK = 8'hFE;
  localparam logic [7:0] CPU_WMASK  = 8'h10;
  // -----------------------------------------------------------
  // Reset values and timing
  // -----------------------------------------------------------
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [7:0] BYTE_MAX   = 8'hFF;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [3:0] PS_TOP     = 4'h8;
  // Bus answer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACK  = 1'b1
  } bus_st_t;
endpackage : timer_pkg

/* File: hw/prescaled_timer.sv */
// APB timer with selectable source, prescaler and overflow interrupt
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module prescaled_timer #(
  parameter int PS_W = 9
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Count pin and interrupt
  input  wire logic        external_count_pin,
  input  wire logic        ovf_vector_ack,
  output logic             irq
);
  // -----------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------
  timer_pkg::bus_st_t st_r;
  logic [31:0]    prdata_r;
  logic           pslverr_r;
  logic           irq_r;
  logic [7:0]     ctrl_r;
  logic           gid_r;
  logic           ovf_flag_r;
  logic           pin_flag_r;
  logic           ovf_en_r;
  logic           pin_en_r;
  logic [7:0]     lo_r;
  logic [7:0]     hi_r;
  logic           inh_lo_r;
  logic           inh_hi_r;
  logic [1:0]     phase_r;
  logic           pin_s1_r;
  logic           pin_s2_r;
  logic           pin_s3_r;
  logic [PS_W-1:0] cnt_r;
  logic           ps_s1_r;
  logic           ps_s2_r;
  logic           ps_s3_r;
  logic           access;
  logic           wr;
  logic           wr_ctrl;
  logic           wr_cpu;
  logic           wr_int;
  logic           wr_lo;
  logic           wr_hi;
  logic           instr_tick;
  logic           pin_edge;
  logic           src_evt;
  logic [3:0]     ps_idx;
  logic           prescaler_output;
  logic           inc;
  logic           lo_go;
  logic           carry;
  logic           wrap;
  logic [7:0]     rd_byte;
  logic           mapped;

  // -----------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------
  assign access  = psel & penable & (st_r == timer_pkg::ST_ACK);
  assign wr      = access & pwrite;
  assign wr_ctrl = wr & (paddr == timer_pkg::CTRL_ADDR);
  assign wr_cpu  = wr & (paddr == timer_pkg::CPU_ADDR);
  assign wr_int  = wr & (paddr == timer_pkg::INT_ADDR);
  assign wr_lo   = wr & (paddr == timer_pkg::LO_ADDR);
  assign wr_hi   = wr & (paddr == timer_pkg::HI_ADDR);
  assign pready  = (st_r == timer_pkg::ST_ACK);
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;
  // Read mux, unmapped addresses flagged
  always_comb
  begin
    mapped  = 1'b1;
    rd_byte = timer_pkg::BYTE_RST;
    case (paddr)
      timer_pkg::CTRL_ADDR: rd_byte = ctrl_r;
      timer_pkg::CPU_ADDR:  rd_byte = 8'(gid_r) << timer_pkg::GID_BIT;
      timer_pkg::INT_ADDR:
      begin
        rd_byte[timer_pkg::PINF_BIT] = pin_flag_r;
        rd_byte[timer_pkg::OVFF_BIT] = ovf_flag_r;
        rd_byte[timer_pkg::PINE_BIT] = pin_en_r;
        rd_byte[timer_pkg::OVFE_BIT] = ovf_en_r;
      end
      timer_pkg::LO_ADDR:   rd_byte = lo_r;
      timer_pkg::HI_ADDR:   rd_byte = hi_r;
      default:              mapped  = 1'b0;
    endcase
  end
  // One wait state, then answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r      <= timer_pkg::ST_IDLE;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (st_r == timer_pkg::ST_ACK)
    begin
      st_r      <= timer_pkg::ST_IDLE;
      pslverr_r <= 1'b0;
    end
    else if (psel & penable)
    begin
      st_r      <= timer_pkg::ST_ACK;
      prdata_r  <= {24'h00_0000, rd_byte};
      pslverr_r <= ~mapped;
    end
  end

  // -----------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------
  // Bit zero never written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= timer_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= pwdata[7:0] & timer_pkg::CTRL_WMASK;
  end

  // Global disable and interrupt enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gid_r    <= 1'b0;
      ovf_en_r <= 1'b0;
      pin_en_r <= 1'b0;
    end
    else
    begin
      if (wr_cpu)
        gid_r <= |(pwdata[7:0] & timer_pkg::CPU_WMASK);
      if (wr_int)
      begin
        ovf_en_r <= pwdata[timer_pkg::OVFE_BIT];
        pin_en_r <= pwdata[timer_pkg::PINE_BIT];
      end
    end
  end

  // -----------------------------------------------------------
  // Count sources
  // -----------------------------------------------------------
  // Instruction clock at pclk / 4
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_r <= 2'h0;
    else
      phase_r <= phase_r + 2'h1;
  end
  assign instr_tick = (phase_r == timer_pkg::PHASE_LAST);
  // Pin synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= external_count_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Selected edge and source mux
  assign pin_edge = ctrl_r[timer_pkg::EDGE_BIT] ? (pin_s2_r & ~pin_s3_r)
                                                : (~pin_s2_r & pin_s3_r);
  assign src_evt  = ctrl_r[timer_pkg::SRC_BIT] ? instr_tick : pin_edge;

  // -----------------------------------------------------------
  // Prescaler
  // -----------------------------------------------------------
  // Cleared by any count byte write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (wr_lo | wr_hi)
      cnt_r <= '0;
    else if (src_evt)
      cnt_r <= cnt_r + PS_W'(1);
  end

  // Output bit toggles once per 2**code events, once per 256 events for codes 8 and up
  assign ps_idx = ctrl_r[timer_pkg::PS_MSB] ? timer_pkg::PS_TOP
                  : {1'b0, ctrl_r[timer_pkg::PS_MSB-1:timer_pkg::PS_LSB]};
  assign prescaler_output = cnt_r[ps_idx];

  // Output resynchronised, any change is one increment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ps_s1_r <= 1'b0;
      ps_s2_r <= 1'b0;
      ps_s3_r <= 1'b0;
    end
    else if (wr_lo | wr_hi)
    begin
      ps_s1_r <= 1'b0;
      ps_s2_r <= 1'b0;
      ps_s3_r <= 1'b0;
    end
    else
    begin
      ps_s1_r <= prescaler_output;
      ps_s2_r <= ps_s1_r;
      ps_s3_r <= ps_s2_r;
    end
  end
  assign inc = ps_s2_r ^ ps_s3_r;

  // -----------------------------------------------------------
  // Sixteen-bit count
  // -----------------------------------------------------------
  assign lo_go = inc & ~inh_lo_r & ~wr_lo;
  assign carry = lo_go & (lo_r == timer_pkg::BYTE_MAX);
  assign wrap  = carry & ~inh_hi_r & ~wr_hi & (hi_r == timer_pkg::BYTE_MAX);

  // Bytes with one-cycle write inhibit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_r     <= timer_pkg::BYTE_RST;
      hi_r     <= timer_pkg::BYTE_RST;
      inh_lo_r <= 1'b0;
      inh_hi_r <= 1'b0;
    end
    else
    begin
      inh_lo_r <= wr_lo;
      inh_hi_r <= wr_hi;
      if (wr_lo)
        lo_r <= pwdata[7:0];
      else if (lo_go)
        lo_r <= lo_r + 8'h01;
      if (wr_hi)
        hi_r <= pwdata[7:0];
      else if (carry & ~inh_hi_r)
        hi_r <= hi_r + 8'h01;
    end
  end

  // -----------------------------------------------------------
  // Interrupt flags
  // -----------------------------------------------------------
  // Sticky flags, set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_flag_r <= 1'b0;
      pin_flag_r <= 1'b0;
    end
    else
    begin
      if (wrap)
        ovf_flag_r <= 1'b1;
      else if (ovf_vector_ack | (wr_int & pwdata[timer_pkg::OVFF_BIT]))
        ovf_flag_r <= 1'b0;
      if (pin_edge)
        pin_flag_r <= 1'b1;
      else if (wr_int & pwdata[timer_pkg::PINF_BIT])
        pin_flag_r <= 1'b0;
    end
  end

  // Masked interrupt level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= ~gid_r & ((ovf_flag_r & ovf_en_r) | (pin_flag_r & pin_en_r));
  end

  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  property p_int_src;
    @(posedge pclk) disable iff (!presetn)
    ctrl_r[timer_pkg::SRC_BIT] && instr_tick && !wr_lo && !wr_hi |=> cnt_r == $past(cnt_r) + PS_W'(1);
  endproperty
  a_int_src: assert property (p_int_src) else $error("internal tick not counted");
  property p_rise;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_r[timer_pkg::SRC_BIT] && ctrl_r[timer_pkg::EDGE_BIT] && pin_s2_r && !pin_s3_r
      && !wr_lo && !wr_hi |=> cnt_r == $past(cnt_r) + PS_W'(1);
  endproperty
  a_rise: assert property (p_rise) else $error("rising pin edge not counted");
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    wrap |=> lo_r == 8'h00 && hi_r == 8'h00 && ovf_flag_r;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not zero count and flag");
  property p_mask;
    @(posedge pclk) disable iff (!presetn)
    !ovf_en_r && !pin_en_r |=> !irq_r;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt raised while masked");
  property p_vec;
    @(posedge pclk) disable iff (!presetn)
    ovf_vector_ack && !wrap |=> !ovf_flag_r;
  endproperty
  a_vec: assert property (p_vec) else $error("flag kept after vectoring");
  property p_pinflag;
    @(posedge pclk) disable iff (!presetn)
    pin_edge |=> pin_flag_r;
  endproperty
  a_pinflag: assert property (p_pinflag) else $error("pin edge flag not set");
  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
    wr_lo ##1 !wr_lo |=> lo_r == $past(lo_r);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("low byte moved after write");
  property p_psclr;
    @(posedge pclk) disable iff (!presetn)
    wr_lo || wr_hi |=> cnt_r == '0 ##1 !inc;
  endproperty
  a_psclr: assert property (p_psclr) else $error("prescaler not cleared");
  property p_bit0;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ctrl_r[0] == 1'b0;
  endproperty
  a_bit0: assert property (p_bit0) else $error("control bit zero written");
endmodule : prescaled_timer

/* File: tb/pin_source.sv */
// Behavioural count source that drives the timer's external count pin
`timescale 1ns/1ps
module pin_source (
  // Clock
  input  wire logic pclk,
  // Count pin
  output logic      pin
);
  // Pin idles low and holds its level between toggles
  initial pin = 1'b0;

  // Toggle n times, each change after a rising edge, gap+1 edges apart
  task automatic toggle(input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      pin <= ~pin;
      repeat (gap) @(posedge pclk);
    end
  endtask : toggle
endmodule : pin_source

/* File: tb/sixteen_bit_prescaled_timer_bench.sv */
// Self-checking bench for the prescaled sixteen-bit timer
`timescale 1ns/1ps
module sixteen_bit_prescaled_timer_bench;
  // -----------------------------------------------------------
  // Signals and register map
  // -----------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, ovf_vector_ack;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pin, irq, err;
  logic [3:0]  code;
  int          failures, n_compared, div;
  localparam logic [7:0] ctrl_a = timer_pkg::CTRL_ADDR;
  localparam logic [7:0] cpu_a  = timer_pkg::CPU_ADDR;
  localparam logic [7:0] int_a  = timer_pkg::INT_ADDR;
  localparam logic [7:0] lo_a   = timer_pkg::LO_ADDR;
  localparam logic [7:0] hi_a   = timer_pkg::HI_ADDR;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic s;} row_t;
  // Write flag, address, write data, expected read, expected error
  row_t rows [13] = '{
    '{1'b0, ctrl_a, 32'h0, 32'h0, 1'b0}, '{1'b0, int_a, 32'h0, 32'h0, 1'b0},
    '{1'b0, cpu_a, 32'h0, 32'h0, 1'b0}, '{1'b0, lo_a, 32'h0, 32'h0, 1'b0},
    '{1'b0, hi_a, 32'h0, 32'h0, 1'b0}, '{1'b1, ctrl_a, 32'h0000_00FF, 32'h0, 1'b0},
    '{1'b0, ctrl_a, 32'h0, 32'h0000_00FE, 1'b0}, '{1'b1, ctrl_a, 32'h0, 32'h0, 1'b0},
    '{1'b1, cpu_a, 32'h0000_00FF, 32'h0, 1'b0}, '{1'b0, cpu_a, 32'h0, 32'h0000_0010, 1'b0},
    '{1'b1, cpu_a, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h04, 32'h0000_00FF, 32'h0, 1'b1}};

  // -----------------------------------------------------------
  // Design, count source, clock
  // -----------------------------------------------------------
  prescaled_timer i_prescaled_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(pin), .ovf_vector_ack(ovf_vector_ack), .irq(irq));
  pin_source src (.pclk(pclk), .pin(pin));
  // Free-running 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  // One APB transfer: setup, access, wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      failures++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Value comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk
  // Interrupt line after the registered output settles
  task automatic ichk(input logic e);
    repeat (2) @(posedge pclk);
    chk("irq", 32'(e), 32'(irq));
  endtask : ichk
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // -----------------------------------------------------------
  // Tests
  // -----------------------------------------------------------
  // Watchdog against a hung handshake
  initial
  begin
    #(20 * 60000);
    failures++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, ovf_vector_ack, presetn} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("reg read", rows[i].e, rd);
      chk("slave error", 32'(rows[i].s), 32'(err));
    end
    $display("test register table done");
    // Prescale codes 0 to 8 and 15: 2*div rising pin edges give two increments
    for (int k = 0; k < 10; k++)
    begin
      code = (k == 9) ? 4'hF : 4'(k);
      div = code[3] ? 256 : (1 << code);
      wr(lo_a, 32'h0);
      wr(hi_a, 32'h0);
      wr(ctrl_a, {25'h0, 1'b1, 1'b0, code, 1'b0});
      src.toggle(4 * div, 3);
      repeat (10) @(posedge pclk);
      rchk("count low", lo_a, 32'h0000_0002);
      rchk("count high", hi_a, 32'h0);
    end
    $display("test prescale codes done");
    // A count write drops a half-done prescale
    wr(lo_a, 32'h0);
    wr(ctrl_a, 32'h0000_0042);
    src.toggle(2, 3);
    wr(lo_a, 32'h0);
    src.toggle(2, 3);
    repeat (10) @(posedge pclk);
    rchk("count low", lo_a, 32'h0);
    // Pin edge to increment latency, ratio one: read at 3 and at 7 clocks
    wr(lo_a, 32'h0);
    wr(ctrl_a, 32'h0000_0040);
    src.toggle(1, 0);
    rchk("early count", lo_a, 32'h0);
    rchk("late count", lo_a, 32'h0000_0001);
    $display("test prescaler clear and latency done");
    // Wrap from all ones, flags and interrupt masking
    wr(int_a, 32'h0000_0062);
    rchk("int reg", int_a, 32'h0000_0002);
    ichk(1'b0);
    wr(cpu_a, 32'h0000_0010);
    wr(lo_a, 32'h0000_00FF);
    wr(hi_a, 32'h0000_00FF);
    wr(cpu_a, 32'h0);
    src.toggle(2, 8);
    rchk("int reg", int_a, 32'h0000_0062);
    ichk(1'b1);
    rchk("count low", lo_a, 32'h0);
    rchk("count high", hi_a, 32'h0);
    wr(cpu_a, 32'h0000_0010);
    ichk(1'b0);
    wr(cpu_a, 32'h0);
    ichk(1'b1);
    wr(int_a, 32'h0);
    ichk(1'b0);
    wr(int_a, 32'h0000_0004);
    ichk(1'b1);
    wr(int_a, 32'h0);
    ichk(1'b0);
    rchk("int reg", int_a, 32'h0000_0060);
    @(posedge pclk);
    ovf_vector_ack <= 1'b1;
    @(posedge pclk);
    ovf_vector_ack <= 1'b0;
    rchk("int reg", int_a, 32'h0000_0040);
    wr(int_a, 32'h0000_0040);
    rchk("int reg", int_a, 32'h0);
    $display("test overflow and interrupt done");
    // Falling edge select: fall counts, rise does not
    wr(ctrl_a, 32'h0);
    wr(lo_a, 32'h0);
    src.toggle(2, 8);
    rchk("count low", lo_a, 32'h0000_0001);
    rchk("int reg", int_a, 32'h0000_0040);
    // Internal source: one increment every four clocks
    wr(ctrl_a, 32'h0000_0020);
    wr(lo_a, 32'h0);
    repeat (400) @(posedge pclk);
    apb(1'b0, lo_a, 32'h0);
    chk("internal rate", 32'h1, 32'(rd >= 99 && rd <= 102));
    $display("test edge select and internal source done");
    // Reset in mid-run, with enables and global disable set beforehand
    wr(int_a, 32'h0000_0006);
    wr(cpu_a, 32'h0000_0010);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("irq after reset", 32'h0, 32'(irq));
    rchk("ctrl after reset", ctrl_a, 32'h0);
    rchk("count after reset", lo_a, 32'h0);
    rchk("high after reset", hi_a, 32'h0);
    rchk("int after reset", int_a, 32'h0);
    rchk("cpu after reset", cpu_a, 32'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule : sixteen_bit_prescaled_timer_bench
